// *** inc/tsys_defs.vh ***
// Register indices, field positions, reset values and divider counts of the system timers.
`ifndef TSYS_DEFS_VH
`define TSYS_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address on the bus is four times the index)
// ----------------------------------------------------------------------------
`define TSYS_IDX_W 16
`define TSYS_IDX_B_LOW 16'h00ac
`define TSYS_IDX_B_HIGH 16'h00ad
`define TSYS_IDX_A_LOW 16'h00ae
`define TSYS_IDX_A_HIGH 16'h00af
`define TSYS_IDX_AB_CTRL 16'h00cf
`define TSYS_IDX_C_CTRL 16'ha003
`define TSYS_IDX_C_LOW 16'ha004
`define TSYS_IDX_C_MID 16'ha005
`define TSYS_IDX_C_TOP 16'ha006

// ----------------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------------
`define TSYS_ADDR_W 18
`define TSYS_IDX_LSB 2
`define TSYS_IDX_MSB 17
`define TSYS_RDATA_RST 32'h0000_0000

// ----------------------------------------------------------------------------
// timer_ab_control fields
// ----------------------------------------------------------------------------
`define TSYS_AB_B_FLAG 7
`define TSYS_AB_B_MODE 6
`define TSYS_AB_B_RUN 5
`define TSYS_AB_B_IEN 4
`define TSYS_AB_A_FLAG 3
`define TSYS_AB_A_MODE 2
`define TSYS_AB_A_RUN 1
`define TSYS_AB_A_IEN 0

// ----------------------------------------------------------------------------
// timer_c_control fields
// ----------------------------------------------------------------------------
`define TSYS_C_FLAG 7
`define TSYS_C_SEL_HI 6
`define TSYS_C_SEL_LO 5
`define TSYS_C_MODE 4
`define TSYS_C_RUN 3
`define TSYS_C_IEN 0

// ----------------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------------
`define TSYS_BIT_RST 1'b0
`define TSYS_SEL_RST 2'b00
`define TSYS_AB_W 16
`define TSYS_C_W 24

// ----------------------------------------------------------------------------
// Oscillator tick dividers (system clock cycles per tick)
// ----------------------------------------------------------------------------
`define TSYS_DIV_W 10
`define TSYS_FAST_DIV 10'd2
`define TSYS_SLOW_DIV 10'd781
`define TSYS_DIV_ZERO 10'd0
`define TSYS_DIV_ONE 10'd1

`endif

// *** src/tsys_counter.v ***
// Byte-writable up counter with reload register, shared by all three timers.
`timescale 1ns/1ps
`default_nettype none

module tsys_counter #(
    parameter W = 16
) (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire tick_i,
    input wire run_i,
    input wire reload_mode_i,
    input wire [W/8-1:0] wr_lane_i,
    input wire [7:0] wr_byte_i,
    output wire [W-1:0] count_o,
    output wire ovf_o
);

    localparam NB = W / 8;

    reg [W-1:0] count_reg;
    reg [W-1:0] reload_reg;
    reg ovf_reg;
    wire step;
    wire wrap;
    wire [W-1:0] count_step;
    wire [W-1:0] count_next;
    wire [W-1:0] reload_next;
    wire ovf_next;

    // ------------------------------------------------------------------------
    // Advance, overflow and wrap
    // ------------------------------------------------------------------------
    assign step = tick_i & run_i; // R4 R7 R17
    assign wrap = step & (&count_reg); // R21
    assign ovf_next = wrap;
    assign count_step = wrap ? (reload_mode_i ? reload_reg : {W{1'b0}}) : // R21
                        (step ? count_reg + {{(W-1){1'b0}}, 1'b1} : count_reg);

    // ------------------------------------------------------------------------
    // Byte writes
    // ------------------------------------------------------------------------
    // A free-run write beats a same-cycle advance, so software always sees
    // exactly the byte it wrote.
    genvar i;
    generate
        for (i = 0; i < NB; i = i + 1) begin : g_lane
            assign count_next[8*i +: 8] = (wr_lane_i[i] & ~reload_mode_i) ?
                                          wr_byte_i : count_step[8*i +: 8]; // R10 R20
            assign reload_next[8*i +: 8] = (wr_lane_i[i] & reload_mode_i) ?
                                           wr_byte_i : reload_reg[8*i +: 8]; // R10 R20
        end
    endgenerate

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_reg <= {W{1'b0}};
            reload_reg <= {W{1'b0}};
            ovf_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            reload_reg <= reload_next;
            ovf_reg <= ovf_next;
        end
    end

    assign count_o = count_reg;
    assign ovf_o = ovf_reg;

endmodule

`default_nettype wire

// *** src/tsys_timers.v ***
// Three system timers (two 16-bit, one 24-bit) behind an Avalon-MM slave.
`timescale 1ns/1ps
`default_nettype none
`include "tsys_defs.vh"

// Function
// R1 - Two 16-bit timers on system clock
// R2 - timer_b overflow sets flag until cleared
// R3 - timer_b mode: 1 reload, 0 free-run
// R4 - timer_b counts only while run set
// R5 - timer_b enable gates overflow request
// R6 - timer_a mode: 1 reload, 0 free-run
// R7 - timer_a counts only while run set
// R8 - timer_a enable gates overflow request
// R9 - timer_a overflow sets flag until cleared
// R10 - 16-bit byte write: reload or live count
// R11 - Reads always return live counter bytes
// R12 - Software reads high byte before low
// R13 - timer_c is a 24-bit timer
// R14 - Select 0x picks fast, 1x slow oscillator
// R15 - timer_c runs without system clock
// R16 - timer_c mode: 1 reload, 0 free-run
// R17 - timer_c counts only while run set
// R18 - timer_c overflow sets flag until cleared
// R19 - timer_c enable gates overflow request
// R20 - 24-bit byte write: reload or live count
// R21 - All-ones advance overflows, reloads or wraps
// R22 - Request high while flag and enable set
module tsys_timers (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire system_clock_run_i,
    input wire fast_internal_osc_on_i,
    input wire slow_internal_osc_on_i,
    input wire [`TSYS_ADDR_W-1:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    output wire timer_a_irq_o,
    output wire timer_b_irq_o,
    output wire timer_c_irq_o
);

    // ------------------------------------------------------------------------
    // Decode helper
    // ------------------------------------------------------------------------
    function tsys_hit;
        input [`TSYS_IDX_W-1:0] idx;
        input [`TSYS_IDX_W-1:0] target;
        begin
            tsys_hit = (idx == target);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg wait_reg;
    reg wait_next;
    reg [31:0] rdata_reg;
    reg [31:0] rdata_next;
    reg [7:0] rbyte;
    reg irq_a_reg;
    reg irq_b_reg;
    reg irq_c_reg;

    reg a_flag_reg;
    reg a_flag_next;
    reg a_mode_reg;
    reg a_run_reg;
    reg a_ien_reg;
    reg b_flag_reg;
    reg b_flag_next;
    reg b_mode_reg;
    reg b_run_reg;
    reg b_ien_reg;
    reg c_flag_reg;
    reg c_flag_next;
    reg [1:0] c_sel_reg;
    reg c_mode_reg;
    reg c_run_reg;
    reg c_ien_reg;

    reg [`TSYS_DIV_W-1:0] fast_div_reg;
    reg [`TSYS_DIV_W-1:0] slow_div_reg;
    reg fast_tick_reg;
    reg slow_tick_reg;

    wire [`TSYS_IDX_W-1:0] idx;
    wire req;
    wire wr_fire;
    wire wr_ab_ctrl;
    wire wr_c_ctrl;
    wire [7:0] wbyte;
    wire [1:0] a_lane;
    wire [1:0] b_lane;
    wire [2:0] c_lane;
    wire [`TSYS_AB_W-1:0] a_count;
    wire [`TSYS_AB_W-1:0] b_count;
    wire [`TSYS_C_W-1:0] c_count;
    wire a_ovf;
    wire b_ovf;
    wire c_ovf;
    wire ab_tick;
    wire c_tick;
    wire [7:0] ab_ctrl_view;
    wire [7:0] c_ctrl_view;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    // Only byte lane 0 carries register data; a write with lane 0 disabled
    // completes on the bus but changes nothing.
    assign idx = avs_address_i[`TSYS_IDX_MSB:`TSYS_IDX_LSB];
    assign req = avs_read_i | avs_write_i;
    assign wr_fire = avs_write_i & ~wait_reg & avs_byteenable_i[0];
    assign wbyte = avs_writedata_i[7:0];
    assign wr_ab_ctrl = wr_fire & tsys_hit(idx, `TSYS_IDX_AB_CTRL);
    assign wr_c_ctrl = wr_fire & tsys_hit(idx, `TSYS_IDX_C_CTRL);
    assign a_lane = {tsys_hit(idx, `TSYS_IDX_A_HIGH), tsys_hit(idx, `TSYS_IDX_A_LOW)}
                    & {2{wr_fire}};
    assign b_lane = {tsys_hit(idx, `TSYS_IDX_B_HIGH), tsys_hit(idx, `TSYS_IDX_B_LOW)}
                    & {2{wr_fire}};
    assign c_lane = {tsys_hit(idx, `TSYS_IDX_C_TOP), tsys_hit(idx, `TSYS_IDX_C_MID),
                     tsys_hit(idx, `TSYS_IDX_C_LOW)} & {3{wr_fire}};

    // ------------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------------
    // Every access takes exactly one wait cycle: the first edge of a request
    // drops waitrequest and captures read data, the second edge completes it.
    always @* begin
        wait_next = 1'b1;
        if (req && wait_reg) begin
            wait_next = 1'b0;
        end
    end

    assign ab_ctrl_view = {b_flag_reg, b_mode_reg, b_run_reg, b_ien_reg,
                           a_flag_reg, a_mode_reg, a_run_reg, a_ien_reg};
    assign c_ctrl_view = {c_flag_reg, c_sel_reg, c_mode_reg, c_run_reg, 2'b00, c_ien_reg};

    always @* begin
        rbyte = 8'h00;
        case (idx)
            `TSYS_IDX_A_LOW: begin
                rbyte = a_count[7:0]; // R11
            end
            `TSYS_IDX_A_HIGH: begin
                rbyte = a_count[15:8]; // R11
            end
            `TSYS_IDX_B_LOW: begin
                rbyte = b_count[7:0]; // R11
            end
            `TSYS_IDX_B_HIGH: begin
                rbyte = b_count[15:8]; // R11
            end
            `TSYS_IDX_AB_CTRL: begin
                rbyte = ab_ctrl_view;
            end
            `TSYS_IDX_C_CTRL: begin
                rbyte = c_ctrl_view;
            end
            `TSYS_IDX_C_LOW: begin
                rbyte = c_count[7:0]; // R11
            end
            `TSYS_IDX_C_MID: begin
                rbyte = c_count[15:8]; // R11
            end
            `TSYS_IDX_C_TOP: begin
                rbyte = c_count[23:16]; // R11
            end
            default: begin
                rbyte = 8'h00;
            end
        endcase
    end

    always @* begin
        rdata_next = rdata_reg;
        if (avs_read_i && wait_reg) begin
            rdata_next = {24'h00_0000, rbyte};
        end
    end

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_reg <= 1'b1;
            rdata_reg <= `TSYS_RDATA_RST;
        end else begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------------
    // Oscillator tick dividers
    // ------------------------------------------------------------------------
    // Both oscillators are modelled as enables carved from the always-on
    // clock; timer_c never looks at the system clock run gate.
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fast_div_reg <= `TSYS_DIV_ZERO;
            slow_div_reg <= `TSYS_DIV_ZERO;
            fast_tick_reg <= 1'b0;
            slow_tick_reg <= 1'b0;
        end else begin
            if (fast_div_reg == `TSYS_FAST_DIV - `TSYS_DIV_ONE) begin
                fast_div_reg <= `TSYS_DIV_ZERO;
                fast_tick_reg <= fast_internal_osc_on_i;
            end else begin
                fast_div_reg <= fast_div_reg + `TSYS_DIV_ONE;
                fast_tick_reg <= 1'b0;
            end
            if (slow_div_reg == `TSYS_SLOW_DIV - `TSYS_DIV_ONE) begin
                slow_div_reg <= `TSYS_DIV_ZERO;
                slow_tick_reg <= slow_internal_osc_on_i;
            end else begin
                slow_div_reg <= slow_div_reg + `TSYS_DIV_ONE;
                slow_tick_reg <= 1'b0;
            end
        end
    end

    assign ab_tick = system_clock_run_i; // R1
    assign c_tick = c_sel_reg[1] ? slow_tick_reg : fast_tick_reg; // R14 R15

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    // A hardware overflow beats a software clear in the same cycle, so no
    // overflow is lost to a racing clear.
    always @* begin
        a_flag_next = wr_ab_ctrl ? wbyte[`TSYS_AB_A_FLAG] : a_flag_reg;
        b_flag_next = wr_ab_ctrl ? wbyte[`TSYS_AB_B_FLAG] : b_flag_reg;
        c_flag_next = wr_c_ctrl ? wbyte[`TSYS_C_FLAG] : c_flag_reg;
        if (a_ovf) begin
            a_flag_next = 1'b1; // R9
        end
        if (b_ovf) begin
            b_flag_next = 1'b1; // R2
        end
        if (c_ovf) begin
            c_flag_next = 1'b1; // R18
        end
    end

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            a_flag_reg <= `TSYS_BIT_RST;
            a_mode_reg <= `TSYS_BIT_RST;
            a_run_reg <= `TSYS_BIT_RST;
            a_ien_reg <= `TSYS_BIT_RST;
            b_flag_reg <= `TSYS_BIT_RST;
            b_mode_reg <= `TSYS_BIT_RST;
            b_run_reg <= `TSYS_BIT_RST;
            b_ien_reg <= `TSYS_BIT_RST;
            c_flag_reg <= `TSYS_BIT_RST;
            c_sel_reg <= `TSYS_SEL_RST;
            c_mode_reg <= `TSYS_BIT_RST;
            c_run_reg <= `TSYS_BIT_RST;
            c_ien_reg <= `TSYS_BIT_RST;
        end else begin
            a_flag_reg <= a_flag_next; // R9
            b_flag_reg <= b_flag_next; // R2
            c_flag_reg <= c_flag_next; // R18
            if (wr_ab_ctrl) begin
                a_mode_reg <= wbyte[`TSYS_AB_A_MODE]; // R6
                a_run_reg <= wbyte[`TSYS_AB_A_RUN]; // R7
                a_ien_reg <= wbyte[`TSYS_AB_A_IEN]; // R8
                b_mode_reg <= wbyte[`TSYS_AB_B_MODE]; // R3
                b_run_reg <= wbyte[`TSYS_AB_B_RUN]; // R4
                b_ien_reg <= wbyte[`TSYS_AB_B_IEN]; // R5
            end
            if (wr_c_ctrl) begin
                c_sel_reg <= wbyte[`TSYS_C_SEL_HI:`TSYS_C_SEL_LO]; // R14
                c_mode_reg <= wbyte[`TSYS_C_MODE]; // R16
                c_run_reg <= wbyte[`TSYS_C_RUN]; // R17
                c_ien_reg <= wbyte[`TSYS_C_IEN]; // R19
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------------------
    // Built from next-state values so the request tracks flag and enable
    // in the same cycle as the registers show them.
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_a_reg <= 1'b0;
            irq_b_reg <= 1'b0;
            irq_c_reg <= 1'b0;
        end else begin
            irq_a_reg <= a_flag_next & (wr_ab_ctrl ? wbyte[`TSYS_AB_A_IEN] : a_ien_reg); // R8 R22
            irq_b_reg <= b_flag_next & (wr_ab_ctrl ? wbyte[`TSYS_AB_B_IEN] : b_ien_reg); // R5 R22
            irq_c_reg <= c_flag_next & (wr_c_ctrl ? wbyte[`TSYS_C_IEN] : c_ien_reg); // R19 R22
        end
    end

    // ------------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------------
    tsys_counter #(
        .W(`TSYS_AB_W)
    ) u_timer_a (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(ab_tick),
        .run_i(a_run_reg),
        .reload_mode_i(a_mode_reg),
        .wr_lane_i(a_lane),
        .wr_byte_i(wbyte),
        .count_o(a_count),
        .ovf_o(a_ovf)
    );

    tsys_counter #(
        .W(`TSYS_AB_W)
    ) u_timer_b (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(ab_tick),
        .run_i(b_run_reg),
        .reload_mode_i(b_mode_reg),
        .wr_lane_i(b_lane),
        .wr_byte_i(wbyte),
        .count_o(b_count),
        .ovf_o(b_ovf)
    );

    tsys_counter #(
        .W(`TSYS_C_W)
    ) u_timer_c (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(c_tick),
        .run_i(c_run_reg),
        .reload_mode_i(c_mode_reg),
        .wr_lane_i(c_lane),
        .wr_byte_i(wbyte),
        .count_o(c_count),
        .ovf_o(c_ovf)
    ); // R13

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign timer_a_irq_o = irq_a_reg;
    assign timer_b_irq_o = irq_b_reg;
    assign timer_c_irq_o = irq_c_reg;

endmodule

`default_nettype wire

// *** sim/tsys_timers_checker.sv ***
// Concurrent checks on the bus handshake and interrupt outputs of the system timers.
`timescale 1ns/1ps
`default_nettype none
`include "tsys_defs.vh"
module tsys_timers_checker (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [`TSYS_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic timer_a_irq_o,
    input wire logic timer_b_irq_o,
    input wire logic timer_c_irq_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    wire logic [15:0] idx;
    wire logic wr_land;
    wire logic ab_wr;
    wire logic c_wr;
    assign idx = avs_address_i[`TSYS_IDX_MSB:`TSYS_IDX_LSB];
    // A write lands only at the edge where waitrequest is sampled low, with lane 0 enabled.
    assign wr_land = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign ab_wr = wr_land && idx == `TSYS_IDX_AB_CTRL;
    assign c_wr = wr_land && idx == `TSYS_IDX_C_CTRL;
    // ------------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------------
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_ack;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    wait_answer_a: assert property (s_req |=> s_ack)
        else $error("bus access not answered in one cycle");
    wait_cause_a: assert property ($fell(avs_waitrequest_o) |->
        $past(avs_read_i || avs_write_i))
        else $error("waitrequest dropped without a request");
    rdata_upper_a: assert property (avs_readdata_o[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    rdata_hold_a: assert property ($changed(avs_readdata_o) |->
        !avs_waitrequest_o && $past(avs_read_i))
        else $error("read data moved outside a read answer");
    // ------------------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------------------
    irq_a_fall_a: assert property ($fell(timer_a_irq_o) |-> $past(ab_wr))
        else $error("timer a request fell without a control write");
    irq_b_fall_a: assert property ($fell(timer_b_irq_o) |-> $past(ab_wr))
        else $error("timer b request fell without a control write");
    irq_c_fall_a: assert property ($fell(timer_c_irq_o) |-> $past(c_wr))
        else $error("timer c request fell without a control write");
    irq_a_gate_a: assert property ($past(ab_wr && !avs_writedata_i[0]) |-> !timer_a_irq_o)
        else $error("timer a request high with enable cleared");
    irq_b_gate_a: assert property ($past(ab_wr && !avs_writedata_i[4]) |-> !timer_b_irq_o)
        else $error("timer b request high with enable cleared");
    irq_c_gate_a: assert property ($past(c_wr && !avs_writedata_i[0]) |-> !timer_c_irq_o)
        else $error("timer c request high with enable cleared");
endmodule
bind tsys_timers tsys_timers_checker u_chk (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .timer_a_irq_o(timer_a_irq_o),
    .timer_b_irq_o(timer_b_irq_o),
    .timer_c_irq_o(timer_c_irq_o)
);
`default_nettype wire

// *** sim/test_system_timers_16_16_24.sv ***
// Self-checking bench for the three system timers.
`timescale 1ns/1ps
`default_nettype none
`include "tsys_defs.vh"
module test_system_timers_16_16_24;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic sys_run = 1'b1;
    logic fast_on = 1'b1;
    logic slow_on = 1'b0;
    logic [17:0] adr = 18'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    wire logic [31:0] rdat;
    wire logic wreq;
    wire logic irq_a;
    wire logic irq_b;
    wire logic irq_c;
    integer errors = 0;
    integer checked = 0;
    logic [7:0] v;
    tsys_timers u_dut (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .system_clock_run_i(sys_run),
        .fast_internal_osc_on_i(fast_on),
        .slow_internal_osc_on_i(slow_on),
        .avs_address_i(adr),
        .avs_read_i(rd),
        .avs_write_i(wr),
        .avs_writedata_i(wdat),
        .avs_byteenable_i(4'h1),
        .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq),
        .timer_a_irq_o(irq_a),
        .timer_b_irq_o(irq_b),
        .timer_c_irq_o(irq_c)
    );
    initial begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    // ------------------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------------------
    task chk8(input logic [7:0] g, input logic [7:0] e);
        begin
            checked = checked + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task chk1(input logic g, input logic e);
        begin
            chk8({7'h0, g}, {7'h0, e});
        end
    endtask
    // Holds the request until waitrequest is sampled low, then leaves one idle edge
    // so that the next request never reassigns a strobe in the same time step.
    // A missing answer is left to the watchdog, which counts it and ends the run.
    task bus(input logic is_wr, input logic [15:0] i, input logic [7:0] d);
        begin
            adr <= {i, 2'b00};
            wr <= is_wr;
            rd <= !is_wr;
            wdat <= {24'h0, d};
            @(posedge sys_clk_i);
            while (wreq !== 1'b0) @(posedge sys_clk_i);
            v = rdat[7:0];
            wr <= 1'b0;
            rd <= 1'b0;
            @(posedge sys_clk_i);
        end
    endtask
    task rdchk(input logic [15:0] i, input logic [7:0] e);
        begin
            bus(1'b0, i, 8'h00);
            chk8(v, e);
        end
    endtask
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task t_reset;
        logic [15:0] ids [0:9];
        integer k;
        begin
            ids = '{`TSYS_IDX_B_LOW, `TSYS_IDX_B_HIGH, `TSYS_IDX_A_LOW, `TSYS_IDX_A_HIGH,
                `TSYS_IDX_AB_CTRL, `TSYS_IDX_C_CTRL, `TSYS_IDX_C_LOW, `TSYS_IDX_C_MID,
                `TSYS_IDX_C_TOP, 16'h0100};
            for (k = 0; k < 10; k = k + 1) rdchk(ids[k], 8'h00);
        end
    endtask
    task t_ab(input logic [15:0] lo, input logic [15:0] hi, input integer sh);
        logic [7:0] x;
        begin
            bus(1'b1, `TSYS_IDX_AB_CTRL, 8'h00);
            bus(1'b1, hi, 8'hff);
            bus(1'b1, lo, 8'hf0);
            rdchk(hi, 8'hff);
            rdchk(lo, 8'hf0);
            bus(1'b1, `TSYS_IDX_AB_CTRL, 8'h4 << sh);
            bus(1'b1, hi, 8'h12);
            bus(1'b1, lo, 8'h34);
            rdchk(hi, 8'hff);
            rdchk(lo, 8'hf0);
            bus(1'b1, `TSYS_IDX_AB_CTRL, 8'h7 << sh);
            repeat (40) @(posedge sys_clk_i);
            chk1(sh ? irq_b : irq_a, 1'b1);
            chk1(sh ? irq_a : irq_b, 1'b0);
            rdchk(`TSYS_IDX_AB_CTRL, 8'hf << sh);
            rdchk(hi, 8'h12);
            bus(1'b1, `TSYS_IDX_AB_CTRL, 8'he << sh);
            chk1(sh ? irq_b : irq_a, 1'b0);
            rdchk(`TSYS_IDX_AB_CTRL, 8'he << sh);
            bus(1'b1, `TSYS_IDX_AB_CTRL, 8'h2 << sh);
            rdchk(`TSYS_IDX_AB_CTRL, 8'h2 << sh);
            sys_run <= 1'b0;
            bus(1'b0, lo, 8'h00);
            x = v;
            rdchk(lo, x);
            sys_run <= 1'b1;
            bus(1'b1, `TSYS_IDX_AB_CTRL, 8'h00);
            bus(1'b0, lo, 8'h00);
            x = v;
            repeat (10) @(posedge sys_clk_i);
            rdchk(lo, x);
            bus(1'b1, hi, 8'hff);
            bus(1'b1, lo, 8'hfe);
            bus(1'b1, `TSYS_IDX_AB_CTRL, 8'h2 << sh);
            repeat (20) @(posedge sys_clk_i);
            rdchk(hi, 8'h00);
            rdchk(`TSYS_IDX_AB_CTRL, 8'ha << sh);
            bus(1'b1, `TSYS_IDX_AB_CTRL, 8'h00);
        end
    endtask
    task t_c;
        logic [7:0] x;
        integer s;
        begin
            sys_run <= 1'b0;
            bus(1'b1, `TSYS_IDX_C_CTRL, 8'h00);
            bus(1'b1, `TSYS_IDX_C_TOP, 8'hff);
            bus(1'b1, `TSYS_IDX_C_MID, 8'hff);
            bus(1'b1, `TSYS_IDX_C_LOW, 8'hf0);
            rdchk(`TSYS_IDX_C_TOP, 8'hff);
            rdchk(`TSYS_IDX_C_MID, 8'hff);
            rdchk(`TSYS_IDX_C_LOW, 8'hf0);
            bus(1'b1, `TSYS_IDX_C_CTRL, 8'h10);
            bus(1'b1, `TSYS_IDX_C_TOP, 8'h56);
            bus(1'b1, `TSYS_IDX_C_MID, 8'h34);
            bus(1'b1, `TSYS_IDX_C_LOW, 8'h12);
            rdchk(`TSYS_IDX_C_TOP, 8'hff);
            bus(1'b1, `TSYS_IDX_C_CTRL, 8'h19);
            repeat (60) @(posedge sys_clk_i);
            chk1(irq_c, 1'b1);
            rdchk(`TSYS_IDX_C_CTRL, 8'h99);
            rdchk(`TSYS_IDX_C_TOP, 8'h56);
            rdchk(`TSYS_IDX_C_MID, 8'h34);
            bus(1'b1, `TSYS_IDX_C_CTRL, 8'h98);
            chk1(irq_c, 1'b0);
            rdchk(`TSYS_IDX_C_CTRL, 8'h98);
            bus(1'b1, `TSYS_IDX_C_CTRL, 8'h18);
            rdchk(`TSYS_IDX_C_CTRL, 8'h18);
            // Slow oscillator is off here, so only the fast codes may advance.
            for (s = 0; s < 4; s = s + 1) begin
                bus(1'b1, `TSYS_IDX_C_CTRL, {1'b0, s[1:0], 5'h08});
                bus(1'b0, `TSYS_IDX_C_LOW, 8'h00);
                x = v;
                repeat (20) @(posedge sys_clk_i);
                bus(1'b0, `TSYS_IDX_C_LOW, 8'h00);
                chk1(v !== x, s < 2);
            end
            slow_on <= 1'b1;
            fast_on <= 1'b0;
            bus(1'b0, `TSYS_IDX_C_LOW, 8'h00);
            x = v;
            repeat (800) @(posedge sys_clk_i);
            bus(1'b0, `TSYS_IDX_C_LOW, 8'h00);
            chk1(v !== x, 1'b1);
            fast_on <= 1'b1;
            bus(1'b1, `TSYS_IDX_C_CTRL, 8'h00);
            bus(1'b0, `TSYS_IDX_C_LOW, 8'h00);
            x = v;
            repeat (20) @(posedge sys_clk_i);
            rdchk(`TSYS_IDX_C_LOW, x);
            sys_run <= 1'b1;
        end
    endtask
    // ------------------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------------------
    task final_report;
        begin
            $display("counts: errors=%0d checked=%0d", errors, checked);
            if (errors == 0 && checked > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (12) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        t_reset;
        t_ab(`TSYS_IDX_A_LOW, `TSYS_IDX_A_HIGH, 0);
        t_ab(`TSYS_IDX_B_LOW, `TSYS_IDX_B_HIGH, 4);
        t_c;
        final_report;
    end
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        errors = errors + 1;
        final_report;
    end
endmodule
`default_nettype wire
